// [hw/lcwp_pkg.sv]
package lcwp_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_DIV      = 8'h04;
  localparam logic [7:0] ADDR_CAP      = 8'h08;
  localparam logic [7:0] ADDR_CALZ     = 8'h0c;
  localparam logic [7:0] ADDR_CMD      = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_VALUE    = 8'h18;
  localparam logic [7:0] ADDR_TARE     = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_ST   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

  // Control register field positions
  localparam int F_MODE  = 0;
  localparam int F_BIP   = 2;
  localparam int F_RANGE = 3;
  localparam int F_HIRES = 5;
  localparam int F_FILT  = 6;
  localparam int F_MOT   = 10;
  localparam int F_POZ   = 13;
  localparam int F_ZR    = 15;
  localparam int F_AZT   = 17;
  localparam int F_TARE  = 19;
  localparam int F_KEEP  = 20;
  localparam int F_FMT   = 21;
  localparam int F_CK    = 24;
  localparam int F_CR    = 25;
  localparam int F_LF    = 26;
  localparam int F_RESP  = 27;

  typedef enum logic [1:0] {MODE_COUNT = 2'h0, MODE_WEIGH = 2'h1, MODE_FORCE = 2'h2} lcwp_mode_t;
  typedef enum logic [2:0] {
    FMT_OFF = 3'h0, FMT_CONT = 3'h1, FMT_QUERY = 3'h2, FMT_MB_HL = 3'h3, FMT_MB_LH = 3'h4, FMT_TOOL = 3'h5
  } lcwp_fmt_t;
  typedef enum logic [1:0] {PH_BOOT = 2'b00, PH_LOAD = 2'b01, PH_RUN = 2'b11} lcwp_phase_t;

  // Defaults; range codes 0..3 are 5, 10, 15, 18 mV
  localparam logic [1:0] RANGE_DEF = 2'h1;
  localparam logic [3:0] FILT_DEF  = 4'h7;
  localparam logic [3:0] FILT_MAX  = 4'h9;
  localparam logic [2:0] MOT_DEF   = 3'h1;
  localparam logic [1:0] ZR_DEF    = 2'h1;
  localparam logic [31:0] CTRL_RESET =
      (32'(RANGE_DEF) << F_RANGE) | (32'(FILT_DEF) << F_FILT) | (32'(MOT_DEF) << F_MOT) |
      (32'(ZR_DEF) << F_ZR) | (32'h1 << F_TARE) | (32'h1 << F_KEEP) | (32'(FMT_QUERY) << F_FMT) |
      (32'h1 << F_CK) | (32'h1 << F_CR) | (32'h1 << F_LF);
  localparam logic [15:0] DIV_RESET  = 16'h0001;
  localparam logic [23:0] CAP_RESET  = 24'h0f4240;

  // Windows: tenths of a division, counts, percent of capacity
  localparam logic [2:0]  MOT_OFF = 3'h4;
  localparam logic [31:0] MOT_E10 [4] = '{32'h3, 32'h5, 32'ha, 32'h14};
  localparam logic [31:0] MOT_CNT [4] = '{32'h3c, 32'h64, 32'hc8, 32'h190};
  localparam logic [31:0] AZT_E10 [4] = '{32'h0, 32'h5, 32'ha, 32'h1e};
  localparam logic [31:0] POZ_PCT [4] = '{32'h0, 32'h2, 32'ha, 32'h0};
  localparam logic [31:0] ZR_PCT  [4] = '{32'h0, 32'h2, 32'h14, 32'h28};
  localparam logic [31:0] PCT_BASE  = 32'h64;
  localparam logic [31:0] HIRES_MUL = 32'ha;
  localparam logic [31:0] TENTHS    = 32'ha;

  localparam logic [31:0] SPAN_UNI = 32'h000f4240;
  localparam logic [31:0] SPAN_BIP = 32'h001e8480;

  // Command and interrupt bits
  localparam int CMD_ZERO     = 0;
  localparam int CMD_TARE     = 1;
  localparam int CMD_CLR_TARE = 2;
  localparam int IRQ_SAMPLE   = 0;
  localparam int IRQ_ZERO     = 1;
  localparam int IRQ_TARE     = 2;
  localparam int IRQ_REJECT   = 3;
  localparam int IRQ_W        = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Delayed answer timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MB_DELAY_NS   = 20000000;
  localparam int MB_DELAY_CYC  = (MB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [hw/lcwp_top.sv]
// Behaviour
// - Service resolution gives tenfold finer weight
// - Filter strength level 0..9, default 7
// - Weigh/force motion window in divisions, or off
// - Count mode motion window in counts, or off
// - Power-on zero only within selected drift
// - Zero command needs stability and range
// - Auto zero tracking inside window and range
// - Tare needs positive gross and no motion
// - Retained tare restores net mode at power-on
// - Serial format selection, default slave query
// - Checksum appended only when enabled
// - Continuous records end with enabled CR, LF
// - Modbus answer immediate or delayed 20 ms
// - Tool connection overrides format, then resumes
// - Count, weighing and force output modes
// - Reset default is count mode, 10 mV unipolar
// - Count span 1,000,000 unipolar, 2,000,000 bipolar
`timescale 1ns/1ns
`default_nettype none
module lcwp_top #(
  parameter int MB_DELAY_CYC = lcwp_pkg::MB_DELAY_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // AXI4-Lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Converter samples
  input  wire logic [23:0] adc_count,
  input  wire logic        adc_valid,
  output logic [1:0]       adc_range,
  output logic             adc_bipolar,
  // Retained tare store
  input  wire logic [31:0] nv_tare_in,
  input  wire logic        nv_net_in,
  output logic [31:0]      nv_tare_out,
  output logic             nv_net_out,
  output logic             nv_write,
  // Serial port control
  input  wire logic        tool_connect,
  input  wire logic        mb_request,
  output logic [2:0]       fmt_active,
  output logic             ck_append,
  output logic             cr_append,
  output logic             lf_append,
  output logic             mb_answer_go,
  // Results
  output logic [31:0]      meas_value,
  output logic             meas_valid,
  output logic             stable,
  output logic             net_mode,
  output logic             irq
);

  localparam int MBW = $clog2(MB_DELAY_CYC + 1);

  typedef struct packed {
    lcwp_pkg::lcwp_phase_t phase;
    logic [31:0] ctrl;
    logic [15:0] div;
    logic [23:0] cap;
    logic [23:0] calz;
    logic [31:0] filt;
    logic        calc;
    logic [31:0] zrel;
    logic [31:0] tare;
    logic        net_mode;
    logic        stable;
    logic [31:0] meas;
    logic        meas_valid;
    logic [lcwp_pkg::IRQ_W-1:0] irq_st;
    logic [lcwp_pkg::IRQ_W-1:0] irq_mask;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        tool;
    logic [MBW-1:0] mb_cnt;
    logic        mb_busy;
    logic        mb_go;
    logic        nv_we;
  } lcwp_state_t;

  lcwp_state_t s;
  lcwp_state_t next_s;

  function automatic logic [31:0] lcwp_abs(input logic [31:0] v);
    return v[31] ? 32'(-$signed(v)) : v;
  endfunction

  function automatic logic [31:0] lcwp_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  // Control fields
  logic [1:0] mode;
  logic       bip;
  logic [3:0] flev;
  logic [2:0] mot;
  logic [1:0] poz;
  logic [1:0] zr;
  logic [1:0] auto_zero_tracking_window;
  logic [2:0] fmt;
  assign mode = s.ctrl[lcwp_pkg::F_MODE +: 2];
  assign bip  = s.ctrl[lcwp_pkg::F_BIP];
  assign flev = s.ctrl[lcwp_pkg::F_FILT +: 4];
  assign mot  = s.ctrl[lcwp_pkg::F_MOT +: 3];
  assign poz  = s.ctrl[lcwp_pkg::F_POZ +: 2];
  assign zr   = s.ctrl[lcwp_pkg::F_ZR +: 2];
  assign auto_zero_tracking_window  = s.ctrl[lcwp_pkg::F_AZT +: 2];
  assign fmt  = s.ctrl[lcwp_pkg::F_FMT +: 3];

  logic is_count;
  logic [31:0] div_eff;
  logic [31:0] calz_ext;
  logic [31:0] gross;
  logic [31:0] win_diff;
  logic        win_ok;
  logic        wr_fire;
  logic        rd_fire;
  logic        mb_mode;
  assign is_count = (mode == lcwp_pkg::MODE_COUNT);
  assign div_eff  = (s.div == 16'h0) ? 32'h1 : {16'h0, s.div};
  assign calz_ext = {{8{s.calz[23]}}, s.calz};
  assign gross    = s.filt - calz_ext - s.zrel;
  assign wr_fire  = s_axi_awvalid & s_axi_wvalid & ~s.bvalid;
  assign rd_fire  = s_axi_arvalid & ~s.rvalid;
  assign mb_mode  = ~s.tool & (fmt == lcwp_pkg::FMT_MB_HL || fmt == lcwp_pkg::FMT_MB_LH);

  always_comb begin
    logic [31:0] x;
    logic [31:0] nf;
    logic [31:0] net;
    logic [31:0] val;
    logic [31:0] zlim;
    logic [31:0] plim;
    logic [31:0] wr_data;
    logic [3:0]  ev;
    logic        rd_clr;
    x       = {{8{adc_count[23]}}, adc_count};
    nf      = '0;
    net     = '0;
    val     = '0;
    zlim    = ({8'h0, s.cap} * lcwp_pkg::ZR_PCT[zr]) / lcwp_pkg::PCT_BASE;
    plim    = ({8'h0, s.cap} * lcwp_pkg::POZ_PCT[poz]) / lcwp_pkg::PCT_BASE;
    wr_data = '0;
    ev      = '0;
    rd_clr  = 1'b0;
    win_diff = lcwp_abs(x - s.filt);
    next_s  = s;
    next_s.meas_valid = 1'b0;
    next_s.mb_go      = 1'b0;
    next_s.nv_we      = 1'b0;
    next_s.calc       = 1'b0;
    next_s.tool       = tool_connect;

    // Filter: each level halves the step toward the new sample
    nf = s.filt + 32'($signed(x - s.filt) >>> flev);
    if (s.phase == lcwp_pkg::PH_RUN || s.phase == lcwp_pkg::PH_LOAD) begin
      win_diff = lcwp_abs(nf - s.filt);
    end
    if (mot >= lcwp_pkg::MOT_OFF) begin
      win_ok = 1'b1;
    end else if (is_count) begin
      win_ok = (win_diff <= lcwp_pkg::MOT_CNT[mot[1:0]]);
    end else begin
      // Wide compare so a large step cannot wrap into the window
      win_ok = (36'(win_diff) * 36'(lcwp_pkg::TENTHS) <=
                36'(div_eff) * 36'(lcwp_pkg::MOT_E10[mot[1:0]]));
    end

    case (s.phase)
      lcwp_pkg::PH_BOOT: begin
        // Straps from the store caught one edge after release
        // Keep bit always resets to 1, so the stored flag alone decides
        if (s.ctrl[lcwp_pkg::F_KEEP] && nv_net_in) begin
          next_s.tare     = nv_tare_in;
          next_s.net_mode = 1'b1;
        end
        next_s.phase = lcwp_pkg::PH_LOAD;
      end
      lcwp_pkg::PH_LOAD: begin
        if (adc_valid) begin
          next_s.filt = x;
          if (!is_count && poz != 2'h0 && lcwp_abs(x - calz_ext) <= plim) begin
            next_s.zrel = x - calz_ext;
          end
          next_s.calc  = 1'b1;
          next_s.phase = lcwp_pkg::PH_RUN;
        end
      end
      lcwp_pkg::PH_RUN: begin
        if (adc_valid) begin
          next_s.filt   = nf;
          next_s.stable = win_ok;
          next_s.calc   = 1'b1;
        end
        // Tracking only on a fresh, settled reading
        if (s.calc && !is_count && auto_zero_tracking_window != 2'h0 && zr != 2'h0 && s.stable &&
            36'(lcwp_abs(gross)) * 36'(lcwp_pkg::TENTHS) <= 36'(div_eff) * 36'(lcwp_pkg::AZT_E10[auto_zero_tracking_window]) &&
            lcwp_abs(s.filt - calz_ext) <= zlim) begin
          next_s.zrel = s.filt - calz_ext;
        end
      end
      default: next_s.phase = lcwp_pkg::PH_BOOT;
    endcase

    // Output value per mode
    net = gross - (s.net_mode ? s.tare : 32'h0);
    if (is_count) begin
      val = s.filt;
      if (!bip && $signed(val) < 0) val = '0;
      if ($signed(val) >= $signed(lcwp_pkg::SPAN_UNI)) val = lcwp_pkg::SPAN_UNI - 32'h1;
      if (bip && $signed(val) < -$signed(lcwp_pkg::SPAN_UNI)) val = 32'(-$signed(lcwp_pkg::SPAN_UNI));
    end else begin
      val = 32'($signed(s.ctrl[lcwp_pkg::F_HIRES] ? net * lcwp_pkg::HIRES_MUL : net) / $signed(div_eff));
      if ((mode == lcwp_pkg::MODE_WEIGH || !bip) && $signed(val) < 0) val = '0;
    end
    if (s.calc) begin
      next_s.meas       = val;
      next_s.meas_valid = 1'b1;
      ev[lcwp_pkg::IRQ_SAMPLE] = 1'b1;
    end

    // Register writes
    if (wr_fire) begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = lcwp_pkg::RESP_OKAY;
      if (s_axi_awaddr[31:8] != 24'h0) begin
        next_s.bresp = lcwp_pkg::RESP_SLVERR;
      end else begin
        case ({s_axi_awaddr[7:2], 2'b00})
          lcwp_pkg::ADDR_CTRL: begin
            wr_data = lcwp_merge(s.ctrl, s_axi_wdata, s_axi_wstrb);
            if (wr_data[lcwp_pkg::F_FILT +: 4] > lcwp_pkg::FILT_MAX) wr_data[lcwp_pkg::F_FILT +: 4] = lcwp_pkg::FILT_MAX;
            if (wr_data[lcwp_pkg::F_MODE +: 2] == lcwp_pkg::MODE_COUNT) begin
              wr_data[lcwp_pkg::F_HIRES] = 1'b0;
            end
            next_s.ctrl = wr_data;
          end
          lcwp_pkg::ADDR_DIV:  next_s.div  = 16'(lcwp_merge({16'h0, s.div}, s_axi_wdata, s_axi_wstrb));
          lcwp_pkg::ADDR_CAP:  next_s.cap  = 24'(lcwp_merge({8'h0, s.cap}, s_axi_wdata, s_axi_wstrb));
          lcwp_pkg::ADDR_CALZ: next_s.calz = 24'(lcwp_merge({8'h0, s.calz}, s_axi_wdata, s_axi_wstrb));
          lcwp_pkg::ADDR_IRQ_MASK: next_s.irq_mask = s_axi_wdata[lcwp_pkg::IRQ_W-1:0];
          lcwp_pkg::ADDR_CMD: begin
            if (s_axi_wstrb[0] && s_axi_wdata[lcwp_pkg::CMD_ZERO]) begin
              if (s.phase == lcwp_pkg::PH_RUN && s.stable && zr != 2'h0 &&
                  lcwp_abs(s.filt - calz_ext) <= zlim) begin
                next_s.zrel = s.filt - calz_ext;
                ev[lcwp_pkg::IRQ_ZERO] = 1'b1;
              end else begin
                ev[lcwp_pkg::IRQ_REJECT] = 1'b1;
              end
            end
            if (s_axi_wstrb[0] && s_axi_wdata[lcwp_pkg::CMD_TARE]) begin
              if (s.phase == lcwp_pkg::PH_RUN && !is_count && s.ctrl[lcwp_pkg::F_TARE] &&
                  s.stable && $signed(gross) > 0) begin
                next_s.tare     = gross;
                next_s.net_mode = 1'b1;
                next_s.nv_we    = s.ctrl[lcwp_pkg::F_KEEP];
                ev[lcwp_pkg::IRQ_TARE] = 1'b1;
              end else begin
                ev[lcwp_pkg::IRQ_REJECT] = 1'b1;
              end
            end
            if (s_axi_wstrb[0] && s_axi_wdata[lcwp_pkg::CMD_CLR_TARE]) begin
              next_s.tare     = '0;
              next_s.net_mode = 1'b0;
              next_s.nv_we    = s.ctrl[lcwp_pkg::F_KEEP];
            end
          end
          default: next_s.bresp = lcwp_pkg::RESP_SLVERR;
        endcase
      end
    end else if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Register reads
    if (rd_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = lcwp_pkg::RESP_OKAY;
      next_s.rdata  = '0;
      if (s_axi_araddr[31:8] != 24'h0) begin
        next_s.rresp = lcwp_pkg::RESP_SLVERR;
      end else begin
        case ({s_axi_araddr[7:2], 2'b00})
          lcwp_pkg::ADDR_CTRL:     next_s.rdata = s.ctrl;
          lcwp_pkg::ADDR_DIV:      next_s.rdata = {16'h0, s.div};
          lcwp_pkg::ADDR_CAP:      next_s.rdata = {8'h0, s.cap};
          lcwp_pkg::ADDR_CALZ:     next_s.rdata = {8'h0, s.calz};
          lcwp_pkg::ADDR_CMD:      next_s.rdata = '0;
          lcwp_pkg::ADDR_STATUS:   next_s.rdata = {27'h0, s.tool, (s.phase == lcwp_pkg::PH_RUN), s.zrel != 32'h0,
                                                   s.net_mode, s.stable};
          lcwp_pkg::ADDR_VALUE:    next_s.rdata = s.meas;
          lcwp_pkg::ADDR_TARE:     next_s.rdata = s.tare;
          lcwp_pkg::ADDR_IRQ_MASK: next_s.rdata = {28'h0, s.irq_mask};
          lcwp_pkg::ADDR_IRQ_ST: begin
            next_s.rdata = {28'h0, s.irq_st};
            rd_clr = 1'b1;
          end
          default: next_s.rresp = lcwp_pkg::RESP_SLVERR;
        endcase
      end
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // A new event in the clearing read's cycle survives
    next_s.irq_st = (rd_clr ? 4'h0 : s.irq_st) | ev;

    // Delayed answer gives slow hosts time to turn the line round
    if (s.mb_busy) begin
      if (s.mb_cnt == '0) begin
        next_s.mb_busy = 1'b0;
        next_s.mb_go   = 1'b1;
      end else begin
        next_s.mb_cnt = s.mb_cnt - MBW'(1);
      end
    end else if (mb_request && mb_mode) begin
      if (s.ctrl[lcwp_pkg::F_RESP]) begin
        next_s.mb_busy = 1'b1;
        next_s.mb_cnt  = MBW'(MB_DELAY_CYC - 2);
      end else begin
        next_s.mb_go = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s          <= '0;
      s.phase    <= lcwp_pkg::PH_BOOT;
      s.ctrl     <= lcwp_pkg::CTRL_RESET;
      s.div      <= lcwp_pkg::DIV_RESET;
      s.cap      <= lcwp_pkg::CAP_RESET;
      s.stable   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = ~s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign adc_range     = s.ctrl[lcwp_pkg::F_RANGE +: 2];
  assign adc_bipolar   = bip;
  assign nv_tare_out   = s.tare;
  assign nv_net_out    = s.net_mode;
  assign nv_write      = s.nv_we;
  assign fmt_active    = s.tool ? lcwp_pkg::FMT_TOOL : fmt;
  assign ck_append     = ~s.tool & s.ctrl[lcwp_pkg::F_CK] &
                         (fmt == lcwp_pkg::FMT_CONT || fmt == lcwp_pkg::FMT_QUERY);
  assign cr_append     = ~s.tool & s.ctrl[lcwp_pkg::F_CR] & (fmt == lcwp_pkg::FMT_CONT);
  assign lf_append     = ~s.tool & s.ctrl[lcwp_pkg::F_LF] & (fmt == lcwp_pkg::FMT_CONT);
  assign mb_answer_go  = s.mb_go;
  assign meas_value    = s.meas;
  assign meas_valid    = s.meas_valid;
  assign stable        = s.stable;
  assign net_mode      = s.net_mode;
  assign irq           = |(s.irq_st & s.irq_mask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_reset_mode_range:
    assert property ($fell(reset) |-> mode == lcwp_pkg::MODE_COUNT && adc_range == lcwp_pkg::RANGE_DEF && !bip)
    else $error("reset mode or range wrong");
  a_filter_default:
    assert property ($fell(reset) |-> flev == lcwp_pkg::FILT_DEF && !s.ctrl[lcwp_pkg::F_HIRES])
    else $error("filter default wrong");
  a_format_default:
    assert property ($fell(reset) |-> fmt == lcwp_pkg::FMT_QUERY && ck_append)
    else $error("format default wrong");
  a_motion_clear:
    assert property (s.phase == lcwp_pkg::PH_RUN && adc_valid && !win_ok |=> !stable)
    else $error("stable kept after motion");
  a_tare_cond:
    assert property (s.phase == lcwp_pkg::PH_RUN && $changed(s.tare) && s.tare != 32'h0
                     |-> $past(s.stable) && $past(mode) != lcwp_pkg::MODE_COUNT && net_mode)
    else $error("tare taken without conditions");
  a_zero_cond:
    assert property (s.phase == lcwp_pkg::PH_RUN && $past(s.phase) == lcwp_pkg::PH_RUN && $changed(s.zrel)
                     |-> $past(s.stable) && $past(zr) != 2'h0)
    else $error("zero taken while moving");
  a_mb_immediate:
    assert property (mb_request && mb_mode && !s.mb_busy && !s.ctrl[lcwp_pkg::F_RESP] |=> mb_answer_go)
    else $error("immediate answer missing");
  a_mb_delayed:
    assert property (mb_request && mb_mode && !s.mb_busy && s.ctrl[lcwp_pkg::F_RESP] |=> !mb_answer_go [*8])
    else $error("delayed answer too early");
  a_tool_resume:
    assert property ($fell(tool_connect) |=> fmt_active == fmt ##1 fmt_active == fmt || tool_connect)
    else $error("format not resumed");
  a_crlf_cont:
    assert property (cr_append || lf_append |-> fmt_active == lcwp_pkg::FMT_CONT)
    else $error("cr or lf outside continuous");
  a_count_span:
    assert property (meas_valid && is_count && !bip |-> $signed(meas_value) >= 0 &&
                     meas_value < lcwp_pkg::SPAN_UNI)
    else $error("count out of unipolar span");

endmodule // lcwp_top
`default_nettype wire

// [test/lcwp_host.sv]
`timescale 1ns/1ns
`default_nettype none
module lcwp_host (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Bench control
  input  wire logic ask,
  output int        lat,
  // Serial link side
  output logic      mb_request,
  input  wire logic mb_answer_go
);
  int cnt;
  // Cycles from the request edge to the answer edge
  always_ff @(posedge clk) begin
    if (reset) begin
      mb_request <= 1'b0;
      cnt        <= 0;
      lat        <= 0;
    end else begin
      mb_request <= ask;
      cnt        <= mb_request ? 1 : cnt + 1;
      if (mb_answer_go) lat <= cnt;
    end
  end
endmodule // lcwp_host
`default_nettype wire

// [test/lcwp_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module lcwp_top_tb;
  localparam int DLY = 20;
  localparam logic [7:0]  RA [5] = '{8'h00, 8'h04, 8'h08, 8'h24, 8'h30};
  localparam logic [33:0] RE [5] = '{34'h075885c8, 34'h1, 34'hf4240, 34'h0, 34'h200000000};
  logic        clk = 0, reset = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, ask = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, adc_valid = 0, tool_connect = 0, nv_net_in = 0;
  logic [31:0] nv_tare_in = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, meas_value, nv_tare_out, rd_v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [23:0] adc_count = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mb_request, mb_answer_go;
  logic        ck_append, cr_append, lf_append, meas_valid, stable, net_mode, irq, adc_bipolar, nv_net_out, nv_write;
  logic [1:0]  s_axi_bresp, s_axi_rresp, adc_range, rsp;
  logic [2:0]  fmt_active;
  int          fails = 0, checks_done = 0, lat, nvw = 0;
  lcwp_top #(.MB_DELAY_CYC(DLY)) u_lcwp_top (
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .adc_count, .adc_valid, .adc_range, .adc_bipolar, .nv_tare_in, .nv_net_in,
    .nv_tare_out, .nv_net_out, .nv_write, .tool_connect, .mb_request, .fmt_active, .ck_append,
    .cr_append, .lf_append, .mb_answer_go, .meas_value, .meas_valid, .stable, .net_mode, .irq);
  lcwp_host u_lcwp_host (.clk, .reset, .ask, .lat, .mb_request, .mb_answer_go);
  always #5 clk = ~clk;
  always @(posedge clk) if (nv_write === 1'b1) nvw <= nvw + 1;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit pa;
    bit pw;
    @(posedge clk);
    s_axi_awaddr <= 32'(a);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1;
    pw = 1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && s_axi_awready === 1'b1) pa = 0;
      if (pw && s_axi_wready === 1'b1) pw = 0;
      if (!pa) s_axi_awvalid <= 1'b0;
      if (!pw) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= 32'(a);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic smp(input logic [23:0] c);
    @(posedge clk);
    adc_count <= c;
    adc_valid <= 1'b1;
    @(posedge clk);
    adc_valid <= 1'b0;
    for (int i = 0; i < 4 && meas_valid !== 1'b1; i++) @(negedge clk);
    `CHK(meas_valid, 1'b1)
  endtask
  task automatic mb(input int e);
    @(posedge clk);
    ask <= 1'b1;
    @(posedge clk);
    ask <= 1'b0;
    repeat (DLY + 5) @(posedge clk);
    `CHK(lat, e)
  endtask
  task automatic summarize;
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #60000;
    fails++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    `CHK({fmt_active, adc_range, adc_bipolar, stable, net_mode}, 8'h4a)
    foreach (RA[i]) begin
      rd(RA[i], rd_v, rsp);
      `CHK({rsp, rd_v}, RE[i])
    end
    // Filter level 0 so each result equals its sample clamped to the count span
    wr(8'h00, 32'h07588408);
    smp(24'd500);
    `CHK(meas_value, 32'd500)
    smp(24'd550);
    `CHK(stable, 1'b1)
    smp(24'd900);
    `CHK(stable, 1'b0)
    smp(24'd1200000);
    `CHK(meas_value, 32'd999999)
    wr(8'h00, 32'h0758900c);
    smp(24'he91ca0);
    `CHK({adc_bipolar, meas_value}, 33'h1fff0bdc0)
    `CHK(stable, 1'b1)
    rd(8'h20, rd_v, rsp);
    wr(8'h24, 32'h1);
    smp(24'd500);
    @(negedge clk);
    `CHK(irq, 1'b1)
    rd(8'h20, rd_v, rsp);
    `CHK(rd_v, 32'h1)
    @(negedge clk);
    `CHK(irq, 1'b0)
    // Zero accepted in range, tare refused in count mode
    wr(8'h10, 32'h1);
    wr(8'h10, 32'h2);
    rd(8'h20, rd_v, rsp);
    `CHK({net_mode, rd_v}, 33'ha)
    wr(8'h00, 32'h07788408);
    repeat (2) @(negedge clk);
    `CHK(fmt_active, 3'h3)
    mb(1);
    wr(8'h00, 32'h0f788408);
    mb(DLY);
    @(posedge clk);
    tool_connect <= 1'b1;
    repeat (3) @(negedge clk);
    `CHK(fmt_active, 3'h5)
    @(posedge clk);
    tool_connect <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK(fmt_active, 3'h3)
    wr(8'h00, 32'h00388408);
    repeat (2) @(negedge clk);
    `CHK({fmt_active, ck_append, cr_append, lf_append}, 6'h08)
    wr(8'h00, 32'h07388408);
    repeat (2) @(negedge clk);
    `CHK({fmt_active, ck_append, cr_append, lf_append}, 6'h0f)
    // Weighing at 10 counts a division, zero offset 500 kept
    wr(8'h04, 32'ha);
    wr(8'h00, 32'h07588409);
    smp(24'd2500);
    `CHK(meas_value, 32'd200)
    smp(24'd2503);
    `CHK(stable, 1'b1)
    wr(8'h10, 32'h2);
    @(negedge clk);
    `CHK({net_mode, nv_tare_out}, 33'h1000007d3)
    `CHK(nvw, 1)
    wr(8'h00, 32'h07588429);
    smp(24'd2523);
    `CHK({stable, meas_value}, 33'h14)
    wr(8'h10, 32'h2);
    @(negedge clk);
    `CHK({nvw, nv_tare_out}, {32'd1, 32'h7d3})
    // Power cycle with a stored tare comes back in net mode
    @(posedge clk);
    nv_tare_in <= nv_tare_out;
    nv_net_in <= nv_net_out;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK({net_mode, nv_net_out, nv_tare_out}, 34'h3000007d3)
    summarize();
  end
endmodule // lcwp_top_tb
`default_nettype wire
